// File: logic/poisc_defs.svh
// Constants of the pressure output interpolation and scaling stage.
// Assumes the chain codes arrive in the 16-bit register formats.
//
// Notes on behaviour
// - Sixteen interpolated values are produced for each new chain result.
// - Each chain result serves as endpoint at once, then as start point one sample later.
// - Output runs between the two latest results: one sample latency.
// - Step zero is previous result (new result after reset); step i adds remainder over 16-(i-1).
// - Absolute 16-bit code: 28672 at 0 kPa, 57.5 LSB per kPa.
// - Absolute 12-bit code: zero offset, 28.75 LSB per kPa.
// - Absolute 10-bit code: zero offset, 7.188 LSB per kPa.
// - Zero calibration value uses zero offset and 57.5 LSB per kPa.
// - Nominal scaling holds only at zero calibration; nonzero shifts outputs.
// - Relative 16-bit code: 30144 at constant pressure, 240 LSB per percent.
// - Relative 12-bit code: 736 at constant pressure, 120 LSB per percent.
// - Temperature: 68 at 0 C, 1/C in 8 bits; 17408, 256/C in 16 bits.
// - Temperature: 1088 at 16/C, 272 at 4/C, PSI5 -27 at 1/C.
`ifndef POISC_DEFS_SVH
`define POISC_DEFS_SVH

// ****************************************************************
// Interpolation timing
// ****************************************************************
`define POISC_STEPS          16
`define POISC_CLK_NS         40
`define POISC_SAMPLE_NS      384000
`define POISC_STEP_CYCLES    (`POISC_SAMPLE_NS / `POISC_CLK_NS / `POISC_STEPS)

// ****************************************************************
// Offsets at zero (20-bit signed working width)
// ****************************************************************
`define POISC_ABS16_OFF      20'sh07000
`define POISC_REL16_OFF      20'sh075C0
`define POISC_REL12_OFF      20'sh002E0
`define POISC_REL10_OFF      20'sh000B8
`define POISC_RELP_OFF       (-20'sh00148)
`define POISC_T16_OFF        20'sh04400
`define POISC_T8_OFF         20'sh00044
`define POISC_T12_OFF        20'sh00440
`define POISC_T10_OFF        20'sh00110
`define POISC_TP_OFF         (-20'sh0001B)

// ****************************************************************
// Sensitivity ratios as right shifts from the 16-bit formats
// ****************************************************************
`define POISC_SH_HALF        1
`define POISC_SH_EIGHTH      3
`define POISC_SH_T8          8
`define POISC_SH_T12         4
`define POISC_SH_T10         6

`endif

// File: logic/poisc_pkg.sv
// Types shared by the pressure output interpolation and scaling stage.
// Assumes the constants header is compiled alongside.
package poisc_pkg;

    typedef enum logic [0:0] {
        POISC_IDLE = 1'b0,
        POISC_RUN  = 1'b1
    } poisc_state_t;

    typedef logic signed [19:0] poisc_wide_t;

endpackage

// File: logic/poisc_top.sv
// Interpolator and output scaler between the filter chain and the framer.
// Assumes chain codes and calibration come from logic on clk_i.
`timescale 1ns/10ps
`include "poisc_defs.svh"

module poisc_top
    import poisc_pkg::*;
#(
    parameter int STEP_CYCLES = `POISC_STEP_CYCLES
) (
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    input  wire logic        sample_valid_i,
    input  wire logic [15:0] abs_chain_result_i,
    input  wire logic [15:0] rel_chain_result_i,
    input  wire logic [15:0] temp_chain_result_i,
    input  wire logic [15:0] cal_zero_i,
    input  wire logic        out_ready_i,
    output logic             out_valid_o,
    output logic [15:0]      abs16_o,
    output logic [11:0]      abs12_o,
    output logic [9:0]       abs10_o,
    output logic [15:0]      rel16_o,
    output logic [11:0]      rel12_o,
    output logic [9:0]       rel10_o,
    output logic [9:0]       rel_psi5_o,
    output logic [7:0]       temp8_o,
    output logic [15:0]      temp16_o,
    output logic [11:0]      temp12_o,
    output logic [9:0]       temp10_o,
    output logic [9:0]       temp_psi5_o
);

    localparam int WORD_W = 152;

    // The step timer is sixteen bits wide; refuse counts it cannot hold.
    if (STEP_CYCLES < 1 || STEP_CYCLES > 65535) begin : g_bad_step
        $error("STEP_CYCLES out of range");
    end

    // ****************************************************************
    // Step sequencing
    // ****************************************************************
    poisc_state_t state_ff;
    logic [15:0]  step_cnt_ff;
    logic [3:0]   step_idx_ff;
    logic         emit_ff;
    logic         push;
    logic         in_ready;
    logic         step_fire;

    // A step waits for the previous word to enter the buffer, so a stall
    // at the receiver slows the steps instead of dropping words.
    assign step_fire = (state_ff == POISC_RUN) && !emit_ff
                       && (step_cnt_ff == 16'(STEP_CYCLES - 1))
                       && (step_idx_ff != 4'hF);

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            state_ff <= POISC_IDLE;
        end else if (sample_valid_i) begin
            state_ff <= POISC_RUN;
        end
    end

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            step_cnt_ff <= 16'h0000;
        end else if (sample_valid_i || step_fire) begin
            step_cnt_ff <= 16'h0000;
        end else if (step_cnt_ff != 16'(STEP_CYCLES - 1)) begin
            // The timer parks at its terminal count while a word waits.
            step_cnt_ff <= step_cnt_ff + 16'h0001;
        end
    end

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            step_idx_ff <= 4'h0;
        end else if (sample_valid_i) begin
            step_idx_ff <= 4'h0;
        end else if (step_fire) begin
            step_idx_ff <= step_idx_ff + 4'h1;
        end
    end

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            emit_ff <= 1'b0;
        end else if (sample_valid_i || step_fire) begin
            emit_ff <= 1'b1;
        end else if (push) begin
            emit_ff <= 1'b0;
        end
    end

    // ****************************************************************
    // Interpolation, pressure channels 0 absolute and 1 relative
    // ****************************************************************
    logic [15:0] chain_in [2];
    logic [15:0] interp_out [2];

    assign chain_in[0] = abs_chain_result_i;
    assign chain_in[1] = rel_chain_result_i;

    for (genvar c = 0; c < 2; c++) begin : g_chan
        logic [15:0]       cur_ff;
        logic [15:0]       interp_ff;
        logic signed [17:0] diff;
        logic signed [17:0] quot;
        logic [4:0]        divisor;

        // Step i divides by 16-(i-1); step_idx_ff holds i-1 here.
        // A full divider per channel is spent so that every step is exact.
        assign divisor = 5'(`POISC_STEPS) - {1'b0, step_idx_ff};
        assign diff    = $signed({2'b00, cur_ff})
                         - $signed({2'b00, interp_ff});
        assign quot    = diff / $signed({13'h0000, divisor});

        always_ff @(posedge clk_i or posedge rst_i) begin
            if (rst_i) begin
                cur_ff    <= 16'h0000;
                interp_ff <= 16'h0000;
            end else if (sample_valid_i) begin
                // The fresh result becomes the target; output starts from the prior one,
                // giving one sample of latency, or from the fresh one when idle after reset.
                cur_ff <= chain_in[c];
                if (state_ff == POISC_IDLE) begin
                    interp_ff <= chain_in[c];
                end else begin
                    interp_ff <= cur_ff;
                end
            end else if (step_fire) begin
                interp_ff <= 16'(interp_ff + quot[15:0]);
            end
        end

        assign interp_out[c] = interp_ff;
    end

    // Temperature moves slowly, so it is held per sample, not interpolated.
    logic [15:0] temp_hold_ff;

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            temp_hold_ff <= 16'h0000;
        end else if (sample_valid_i) begin
            temp_hold_ff <= temp_chain_result_i;
        end
    end

    // ****************************************************************
    // Output scaling
    // ****************************************************************
    function automatic logic [15:0] clamp_u(input poisc_wide_t v,
                                            input int bits);
        poisc_wide_t hi;
        hi = poisc_wide_t'((1 << bits) - 1);
        if (v < 0) begin
            clamp_u = 16'h0000;
        end else if (v > hi) begin
            clamp_u = hi[15:0];
        end else begin
            clamp_u = v[15:0];
        end
    endfunction

    function automatic logic [9:0] clamp_s10(input poisc_wide_t v);
        if (v < -20'sh00200) begin
            clamp_s10 = 10'h200;
        end else if (v > 20'sh001FF) begin
            clamp_s10 = 10'h1FF;
        end else begin
            clamp_s10 = v[9:0];
        end
    endfunction

    poisc_wide_t abs_code;
    poisc_wide_t abs_d;
    poisc_wide_t rel_d;
    poisc_wide_t tmp_d;
    logic [WORD_W-1:0] word;

    // The zero calibration is a 57.5 LSB/kPa code without offset and is
    // subtracted as is; nominal figures hold only when it is zero.
    assign abs_code = $signed({4'h0, interp_out[0]})
                      - $signed({4'h0, cal_zero_i});
    assign abs_d    = abs_code - `POISC_ABS16_OFF;
    assign rel_d    = $signed({4'h0, interp_out[1]}) - `POISC_REL16_OFF;
    assign tmp_d    = $signed({4'h0, temp_hold_ff}) - `POISC_T16_OFF;

    // Codes outside a field's range saturate rather than wrap, so a frame
    // never reports a pressure on the far side of the scale.
    always_comb begin
        word = '0;
        word[151:136] = clamp_u(abs_code, 16);
        word[135:124] = 12'(clamp_u(abs_d >>> `POISC_SH_HALF, 12));
        word[123:114] = 10'(clamp_u(abs_d >>> `POISC_SH_EIGHTH, 10));
        word[113:98]  = interp_out[1];
        word[97:86]   = 12'(clamp_u((rel_d >>> `POISC_SH_HALF)
                                    + `POISC_REL12_OFF, 12));
        word[85:76]   = 10'(clamp_u((rel_d >>> `POISC_SH_EIGHTH)
                                    + `POISC_REL10_OFF, 10));
        word[75:66]   = clamp_s10((rel_d >>> `POISC_SH_EIGHTH)
                                  + `POISC_RELP_OFF);
        word[65:58]   = 8'(clamp_u((tmp_d >>> `POISC_SH_T8)
                                   + `POISC_T8_OFF, 8));
        word[57:42]   = temp_hold_ff;
        word[41:30]   = 12'(clamp_u((tmp_d >>> `POISC_SH_T12)
                                    + `POISC_T12_OFF, 12));
        word[29:20]   = 10'(clamp_u((tmp_d >>> `POISC_SH_T10)
                                    + `POISC_T10_OFF, 10));
        word[19:10]   = clamp_s10((tmp_d >>> `POISC_SH_T8)
                                  + `POISC_TP_OFF);
    end

    // ****************************************************************
    // Two-entry output buffer
    // ****************************************************************
    logic [WORD_W-1:0] head_ff;
    logic [WORD_W-1:0] spare_ff;
    logic              head_v_ff;
    logic              spare_v_ff;
    logic              pop;

    assign in_ready = !spare_v_ff;
    assign push     = emit_ff && in_ready && !sample_valid_i && !step_fire;
    assign pop      = head_v_ff && out_ready_i;

    // The head always refills from the spare first, so words keep their
    // order; the spare only fills while the head is held by the receiver.
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            head_v_ff  <= 1'b0;
            spare_v_ff <= 1'b0;
        end else if (pop || !head_v_ff) begin
            head_v_ff  <= spare_v_ff || push;
            spare_v_ff <= spare_v_ff && push;
        end else if (push) begin
            spare_v_ff <= 1'b1;
        end
    end

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            head_ff  <= '0;
            spare_ff <= '0;
        end else if (pop || !head_v_ff) begin
            if (spare_v_ff) begin
                head_ff <= spare_ff;
                if (push) begin
                    spare_ff <= word;
                end
            end else if (push) begin
                head_ff <= word;
            end
        end else if (push) begin
            spare_ff <= word;
        end
    end

    assign out_valid_o = head_v_ff;
    assign abs16_o     = head_ff[151:136];
    assign abs12_o     = head_ff[135:124];
    assign abs10_o     = head_ff[123:114];
    assign rel16_o     = head_ff[113:98];
    assign rel12_o     = head_ff[97:86];
    assign rel10_o     = head_ff[85:76];
    assign rel_psi5_o  = head_ff[75:66];
    assign temp8_o     = head_ff[65:58];
    assign temp16_o    = head_ff[57:42];
    assign temp12_o    = head_ff[41:30];
    assign temp10_o    = head_ff[29:20];
    assign temp_psi5_o = head_ff[19:10];

endmodule // poisc_top

// File: testbench/poisc_top_monitor.sv
// Checker for the output stream of the interpolation and scaling stage.
// Assumes it is bound to poisc_top and sees only that module's ports.
`timescale 1ns/10ps
module poisc_top_monitor #(
    parameter int STEP_CYCLES = 600
) (
    input wire logic        clk_i,
    input wire logic        rst_i,
    input wire logic        sample_valid_i,
    input wire logic        out_ready_i,
    input wire logic        out_valid_o,
    input wire logic [15:0] abs16_o,
    input wire logic [11:0] abs12_o,
    input wire logic [9:0]  abs10_o,
    input wire logic [15:0] rel16_o,
    input wire logic [11:0] rel12_o,
    input wire logic [9:0]  rel10_o,
    input wire logic [9:0]  rel_psi5_o,
    input wire logic [7:0]  temp8_o,
    input wire logic [15:0] temp16_o,
    input wire logic [11:0] temp12_o,
    input wire logic [9:0]  temp10_o,
    input wire logic [9:0]  temp_psi5_o
);
    // ****************************************************************
    // Field relations, all derived from the 16-bit head fields
    // ****************************************************************
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    int d_a;
    int d_r;
    int d_t;
    assign d_a = int'(abs16_o) - 28672;
    assign d_r = int'(rel16_o) - 30144;
    assign d_t = int'(temp16_o) - 17408;
    function automatic int cu(int v, int hi);
        return v < 0 ? 0 : (v > hi ? hi : v);
    endfunction
    function automatic int cs(int v);
        return v < -512 ? -512 : (v > 511 ? 511 : v);
    endfunction
    // A stalled word must not change, or the framer would tear a frame.
    property p_stand;
        out_valid_o && !out_ready_i |=> out_valid_o && $stable(abs16_o)
            && $stable(rel16_o) && $stable(temp16_o);
    endproperty
    a_stand: assert property (p_stand) else $error("stalled word moved");
    property p_latency;
        sample_valid_i && !out_valid_o |-> ##[2:3] out_valid_o;
    endproperty
    a_latency: assert property (p_latency) else $error("no word");
    property p_abs12;
        out_valid_o |-> abs12_o == 12'(cu(d_a >>> 1, 4095));
    endproperty
    a_abs12: assert property (p_abs12) else $error("abs12 wrong");
    property p_abs10;
        out_valid_o |-> abs10_o == 10'(cu(d_a >>> 3, 1023));
    endproperty
    a_abs10: assert property (p_abs10) else $error("abs10 wrong");
    property p_rel12;
        out_valid_o |-> rel12_o == 12'(cu((d_r >>> 1) + 736, 4095));
    endproperty
    a_rel12: assert property (p_rel12) else $error("rel12 wrong");
    property p_rel10;
        out_valid_o |-> rel10_o == 10'(cu((d_r >>> 3) + 184, 1023))
            && rel_psi5_o == 10'(cs((d_r >>> 3) - 328));
    endproperty
    a_rel10: assert property (p_rel10) else $error("rel10 wrong");
    property p_temp8;
        out_valid_o |-> temp8_o == 8'(cu((d_t >>> 8) + 68, 255));
    endproperty
    a_temp8: assert property (p_temp8) else $error("temp8 wrong");
    property p_temp12;
        out_valid_o |-> temp12_o == 12'(cu((d_t >>> 4) + 1088, 4095));
    endproperty
    a_temp12: assert property (p_temp12) else $error("temp12 wrong");
    property p_temp10;
        out_valid_o |-> temp10_o == 10'(cu((d_t >>> 6) + 272, 1023))
            && temp_psi5_o == 10'(cs((d_t >>> 8) - 27));
    endproperty
    a_temp10: assert property (p_temp10) else $error("temp10 wrong");
    c_stall: cover property (out_valid_o && !out_ready_i);
    c_sample: cover property (sample_valid_i);
    c_clamp: cover property (out_valid_o && abs12_o == 12'h000 && d_a < 0);
endmodule // poisc_top_monitor

bind poisc_top poisc_top_monitor #(.STEP_CYCLES(STEP_CYCLES)) u_mon (
    .clk_i, .rst_i, .sample_valid_i, .out_ready_i, .out_valid_o, .abs16_o,
    .abs12_o, .abs10_o, .rel16_o, .rel12_o, .rel10_o, .rel_psi5_o,
    .temp8_o, .temp16_o, .temp12_o, .temp10_o, .temp_psi5_o);

// File: testbench/poisc_sink_model.sv
// Model of the frame formatter that drains the output stream.
// Assumes stall and pacing requests come from the bench on clk_i.
`timescale 1ns/10ps
module poisc_sink_model (
    input  wire logic clk_i,
    input  wire logic rst_i,
    input  wire logic slow_i,
    input  wire logic stall_i,
    output logic      out_ready_o
);
    logic tog_ff;
    // Slow pacing accepts every other cycle, so the buffer sees back pressure.
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            tog_ff <= 1'b0;
        end else begin
            tog_ff <= ~tog_ff;
        end
    end
    assign out_ready_o = !stall_i && (!slow_i || tog_ff);
endmodule // poisc_sink_model

// File: testbench/pressure_output_interp_scaling_bench.sv
// Self-checking bench for the interpolation and scaling stage.
// Assumes the sink model stands in for the frame formatter.
`timescale 1ns/10ps
module pressure_output_interp_scaling_bench;
    localparam int SC = 4;
    localparam int T0 = 17708;
    logic clk_i = 1'b0, rst_i = 1'b1, sample_valid_i = 1'b0;
    logic [15:0] abs_chain_result_i = 16'h0000, rel_chain_result_i = 16'h0000;
    logic [15:0] temp_chain_result_i = 16'h0000, cal_zero_i = 16'h0000;
    logic out_ready_i, out_valid_o, stall = 1'b0, slow = 1'b0;
    logic [15:0] abs16_o, rel16_o, temp16_o;
    logic [11:0] abs12_o, rel12_o, temp12_o;
    logic [9:0]  abs10_o, rel10_o, rel_psi5_o, temp10_o, temp_psi5_o;
    logic [7:0]  temp8_o;
    logic [141:0] q[$];
    time tq[$];
    int n_errors = 0, compares = 0;
    initial forever #20 clk_i = ~clk_i;
    poisc_top #(.STEP_CYCLES(SC)) dut (.clk_i, .rst_i, .sample_valid_i,
        .abs_chain_result_i, .rel_chain_result_i, .temp_chain_result_i,
        .cal_zero_i, .out_ready_i, .out_valid_o, .abs16_o, .abs12_o,
        .abs10_o, .rel16_o, .rel12_o, .rel10_o, .rel_psi5_o, .temp8_o,
        .temp16_o, .temp12_o, .temp10_o, .temp_psi5_o);
    poisc_sink_model sink (.clk_i, .rst_i, .slow_i(slow), .stall_i(stall),
        .out_ready_o(out_ready_i));
    always @(posedge clk_i) begin
        if (!rst_i && out_valid_o === 1'b1 && out_ready_i === 1'b1) begin
            q.push_back({abs16_o, abs12_o, abs10_o, rel16_o, rel12_o, rel10_o,
                rel_psi5_o, temp8_o, temp16_o, temp12_o, temp10_o,
                temp_psi5_o});
            tq.push_back($time);
        end
    end
    function automatic int cu(int v, int hi);
        return v < 0 ? 0 : (v > hi ? hi : v);
    endfunction
    function automatic int cs(int v);
        return v < -512 ? -512 : (v > 511 ? 511 : v);
    endfunction
    function automatic logic [141:0] exp_word(int a, int r, int c);
        int d, rr, tt;
        d = cu(a - c, 65535);
        rr = r - 30144;
        tt = T0 - 17408;
        return {16'(d), 12'(cu((d - 28672) >>> 1, 4095)),
            10'(cu((d - 28672) >>> 3, 1023)), 16'(r),
            12'(cu((rr >>> 1) + 736, 4095)), 10'(cu((rr >>> 3) + 184, 1023)),
            10'(cs((rr >>> 3) - 328)), 8'(cu((tt >>> 8) + 68, 255)), 16'(T0),
            12'(cu((tt >>> 4) + 1088, 4095)), 10'(cu((tt >>> 6) + 272, 1023)),
            10'(cs((tt >>> 8) - 27))};
    endfunction
    task automatic check(logic [141:0] seen, logic [141:0] want);
        compares++;
        if (seen !== want) begin
            n_errors++;
            $display("[FAIL] %0t seen %h want %h", $time, seen, want);
        end
    endtask
    task automatic close_out();
        $display("compares %0d n_errors %0d", compares, n_errors);
        if (n_errors == 0 && compares > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    // ****************************************************************
    // One sample: send it, optionally stall the sink, judge all 16 words
    // ****************************************************************
    task automatic run(int pa, int ca, int pr, int cr, int st);
        int oa, orr, k;
        time t0;
        logic [141:0] w;
        q.delete();
        tq.delete();
        @(posedge clk_i);
        stall <= (st > 0);
        sample_valid_i <= 1'b1;
        abs_chain_result_i <= 16'(ca);
        rel_chain_result_i <= 16'(cr);
        temp_chain_result_i <= 16'(T0);
        @(posedge clk_i);
        t0 = $time;
        sample_valid_i <= 1'b0;
        if (st > 0) begin
            repeat (st) @(posedge clk_i);
            check(142'(q.size()), 142'h0);
            check(142'(out_valid_o), 142'h1);
            stall <= 1'b0;
        end
        k = 0;
        while (q.size() < 16 && k < 800) begin
            @(posedge clk_i);
            k++;
        end
        repeat (3 * SC) @(posedge clk_i);
        check(142'(q.size()), 142'h10);
        if (q.size() < 16)
            close_out();
        oa = pa;
        orr = pr;
        for (int i = 0; i < 16; i++) begin
            if (i > 0) begin
                oa = oa + (ca - oa) / (16 - (i - 1));
                orr = orr + (cr - orr) / (16 - (i - 1));
            end
            w = exp_word(oa, orr, cal_zero_i);
            check(q[i][141:104], w[141:104]);
            check(q[i][103:0], w[103:0]);
            if (st == 0 && slow == 1'b0 && i > 0)
                check(142'(tq[i] - tq[i - 1]), 142'(SC * 40));
        end
        if (st == 0 && slow == 1'b0)
            check(142'(tq[0] - t0), 142'h50);
    endtask
    task automatic t_first();
        run(16'h723F, 16'h723F, 16'h75C0, 16'h75C0, 0);
        $display("first sample done");
    endtask
    task automatic t_interp();
        run(16'h723F, 16'h8676, 16'h75C0, 16'h6C60, 0);
        check(142'(q[0][141:126]), 142'h723F);
        $display("rising ramp done");
    endtask
    task automatic t_stall();
        run(16'h8676, 16'h7B3B, 16'h6C60, 16'h75C0, 40);
        $display("stalled falling ramp done");
    endtask
    task automatic t_cal();
        @(posedge clk_i);
        cal_zero_i <= 16'h1676;
        slow <= 1'b1;
        run(16'h7B3B, 16'h7B3B, 16'h75C0, 16'h75C0, 0);
        check(142'(q[15][141:126]), 142'h64C5);
        $display("calibration shift done");
    endtask
    // After a fresh reset step zero must take the new sample itself.
    task automatic t_reset();
        @(posedge clk_i);
        rst_i <= 1'b1;
        repeat (5) @(posedge clk_i);
        rst_i <= 1'b0;
        run(16'h8676, 16'h8676, 16'h6C60, 16'h6C60, 0);
        $display("reset restart done");
    endtask
    initial begin
        repeat (5) @(posedge clk_i);
        rst_i <= 1'b0;
        t_first();
        t_interp();
        t_stall();
        t_cal();
        t_reset();
        close_out();
    end
endmodule // pressure_output_interp_scaling_bench
